/* File: include/pos_pkg.sv */
// Overview of operation
// RULE1: single update: one duty serves both halves
// RULE2: double update: each half latches own duty
// RULE3: minimum half on-time is min_pulse_count cycles
// RULE4: short pulse held off, complement held on; code turns both pins on when both halves are short
// RULE5: steering register is nine-bit read/write
// RULE6: steering bits 8,7,6 cross phases A,B,C
// RULE7: crossover swaps high and low pin signals
// RULE8: reset clears all three crossover bits
// RULE9: bits 0-5 force one output off each
// RULE10: disable masking applied after crossover routing
// RULE11: reset clears all six disable bits
// RULE12: steering takes effect on sync rising edge
// RULE13: carrier bit 8 chops high, 9 low
// RULE14: carrier period is four times divider plus one
// RULE15: divider accepts every value 0 through 255
// RULE16: reset clears the whole gate carrier register
// RULE17: software sets carrier before starting pwm
// RULE18: chopping modulates only the active portion
// RULE19: midpoint sync relatches duty and steering
// RULE20: on-time shrinks by dead time per edge
// RULE21: carrier is 50 percent square, ANDed last
package pos_pkg;
   localparam int          ADDR_W            = 4;
   localparam int          DATA_W            = 32;
   localparam int          CNT_W             = 16;
   localparam int          NUM_PHASES        = 3;
   localparam int          NUM_OUTS          = 6;
   // register byte offsets
   localparam logic [3:0]  OFS_STEERING      = 4'h0;
   localparam logic [3:0]  OFS_GATE          = 4'h4;
   localparam logic [3:0]  OFS_MIN_PULSE     = 4'h8;
   localparam logic [3:0]  OFS_STATUS        = 4'hC;
   // widths and reset values
   localparam int          STEER_W           = 9;
   localparam int          GATE_W            = 10;
   localparam logic [8:0]  STEER_RESET       = 9'h000;
   localparam logic [9:0]  GATE_RESET        = 10'h000;
   localparam logic [15:0] MIN_PULSE_RESET   = 16'h0000;
   // steering field positions
   localparam int          STEER_XOVER_A_BIT = 8;
   localparam int          STEER_HIGH_A_BIT  = 4;
   localparam int          STEER_LOW_A_BIT   = 5;
   // gate field positions
   localparam int          GATE_DIV_LSB      = 0;
   localparam int          GATE_DIV_W        = 8;
   localparam int          GATE_CHOP_HI_BIT  = 8;
   localparam int          GATE_CHOP_LO_BIT  = 9;
   // status field positions
   localparam int          STAT_DELETE_LSB   = 0;
   localparam int          STAT_PINS_LSB     = 8;
   localparam int          STAT_HALF_BIT     = 16;
endpackage : pos_pkg

/* File: rtl/pos_shaping.sv */
`timescale 1ns/1ps
module pos_shaping
   import pos_pkg::*;
(
   // clock and reset
   input  wire logic                clock,
   input  wire logic                rst,
   // avalon-mm slave
   input  wire logic [ADDR_W-1:0]   avs_address,
   input  wire logic                avs_read,
   input  wire logic                avs_write,
   input  wire logic [DATA_W-1:0]   avs_writedata,
   input  wire logic [3:0]          avs_byteenable,
   output logic [DATA_W-1:0]        avs_readdata,
   output logic                     avs_waitrequest,
   // timing unit side
   input  wire logic                double_update_mode,
   input  wire logic                period_sync_pulse,
   input  wire logic [CNT_W-1:0]    duty_phase_a,
   input  wire logic [CNT_W-1:0]    duty_phase_b,
   input  wire logic [CNT_W-1:0]    duty_phase_c,
   input  wire logic [CNT_W-1:0]    dead_time_count,
   input  wire logic [CNT_W-1:0]    period_count,
   input  wire logic                timing_a_high,
   input  wire logic                timing_a_low,
   input  wire logic                timing_b_high,
   input  wire logic                timing_b_low,
   input  wire logic                timing_c_high,
   input  wire logic                timing_c_low,
   // gate driver pins
   output logic                     phase_a_high,
   output logic                     phase_a_low,
   output logic                     phase_b_high,
   output logic                     phase_b_low,
   output logic                     phase_c_high,
   output logic                     phase_c_low
);

   ////////////////////////////////////////////////////////////////////////
   // registers and internal signals

   logic [STEER_W-1:0]    output_steering_reg;
   logic [STEER_W-1:0]    steer_active_reg;
   logic [GATE_W-1:0]     gate_carrier_reg;
   logic [CNT_W-1:0]      min_pulse_count_reg;
   logic                  wait_reg;
   logic [DATA_W-1:0]     rdata_reg;
   logic                  sync_prev_reg;
   logic                  half_reg;
   logic [NUM_OUTS-1:0]   delete_reg;
   logic [NUM_OUTS-1:0]   pins_reg;
   logic [GATE_DIV_W:0]   chop_cnt_reg;
   logic                  carrier_reg;

   logic                  sync_rise;
   logic                  wr_take;
   logic                  rd_take;
   logic [CNT_W-1:0]      duty_vec     [NUM_PHASES];
   logic [1:0]            timing_vec   [NUM_PHASES];
   logic [NUM_OUTS-1:0]   delete_next;
   logic [NUM_OUTS-1:0]   pins_next;
   logic [GATE_DIV_W:0]   chop_last;
   logic [DATA_W-1:0]     status_word;

   assign duty_vec[0]   = duty_phase_a;
   assign duty_vec[1]   = duty_phase_b;
   assign duty_vec[2]   = duty_phase_c;
   assign timing_vec[0] = {timing_a_low, timing_a_high};
   assign timing_vec[1] = {timing_b_low, timing_b_high};
   assign timing_vec[2] = {timing_c_low, timing_c_high};

   assign sync_rise = period_sync_pulse & ~sync_prev_reg;

   ////////////////////////////////////////////////////////////////////////
   // avalon-mm slave: one wait cycle, then complete

   // request is seen with waitrequest high, then waitrequest drops for
   // exactly one cycle, at whose closing edge the access completes
   assign wr_take = avs_write & ~wait_reg;
   assign rd_take = avs_read & wait_reg;

   always_ff @(posedge clock) begin
      if (rst) begin
         wait_reg <= 1'b1;
      end else if ((avs_read | avs_write) & wait_reg) begin
         wait_reg <= 1'b0;
      end else begin
         wait_reg <= 1'b1;
      end
   end

   always_comb begin
      status_word = '0;
      status_word[STAT_DELETE_LSB +: NUM_OUTS] = delete_reg;
      status_word[STAT_PINS_LSB +: NUM_OUTS]   = pins_reg;
      status_word[STAT_HALF_BIT]               = half_reg;
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         rdata_reg <= '0;
      end else if (rd_take) begin
         if (avs_address == OFS_STEERING) begin
            rdata_reg <= {{(DATA_W-STEER_W){1'b0}}, output_steering_reg};
         end else if (avs_address == OFS_GATE) begin
            rdata_reg <= {{(DATA_W-GATE_W){1'b0}}, gate_carrier_reg};
         end else if (avs_address == OFS_MIN_PULSE) begin
            rdata_reg <= {{(DATA_W-CNT_W){1'b0}}, min_pulse_count_reg};
         end else if (avs_address == OFS_STATUS) begin
            rdata_reg <= status_word;
         end else begin
            rdata_reg <= '0;
         end
      end
   end

   // steering register, software copy
   always_ff @(posedge clock) begin
      if (rst) begin
         output_steering_reg <= STEER_RESET; // RULE8 RULE11
      end else if (wr_take && avs_address == OFS_STEERING) begin
         if (avs_byteenable[0]) begin
            output_steering_reg[7:0] <= avs_writedata[7:0]; // RULE5
         end
         if (avs_byteenable[1]) begin
            output_steering_reg[8] <= avs_writedata[8]; // RULE5
         end
      end
   end

   // gate carrier register; divider accepts the full 8-bit range
   always_ff @(posedge clock) begin
      if (rst) begin
         gate_carrier_reg <= GATE_RESET; // RULE16
      end else if (wr_take && avs_address == OFS_GATE) begin
         if (avs_byteenable[0]) begin
            gate_carrier_reg[7:0] <= avs_writedata[7:0]; // RULE15
         end
         if (avs_byteenable[1]) begin
            gate_carrier_reg[9:8] <= avs_writedata[9:8]; // RULE13
         end
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         min_pulse_count_reg <= MIN_PULSE_RESET;
      end else if (wr_take && avs_address == OFS_MIN_PULSE) begin
         if (avs_byteenable[0]) begin
            min_pulse_count_reg[7:0] <= avs_writedata[7:0];
         end
         if (avs_byteenable[1]) begin
            min_pulse_count_reg[15:8] <= avs_writedata[15:8];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sync latching: period start, plus midpoint in double update mode

   always_ff @(posedge clock) begin
      if (rst) begin
         sync_prev_reg <= 1'b0;
      end else begin
         sync_prev_reg <= period_sync_pulse;
      end
   end

   // half tracker: flips at each sync in double mode, stays 0 in single
   always_ff @(posedge clock) begin
      if (rst) begin
         half_reg <= 1'b0;
      end else if (sync_rise) begin
         half_reg <= double_update_mode & ~half_reg; // RULE19
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         steer_active_reg <= STEER_RESET;
      end else if (sync_rise) begin
         steer_active_reg <= output_steering_reg; // RULE12 RULE19
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // minimum pulse deletion, decided at each sync rise

   // duty values are sampled at every sync rise: once per period in
   // single update mode, so both halves share them; twice in double
   // update mode, so each half gets its own value
   generate
      for (genvar p = 0; p < NUM_PHASES; p++) begin : g_del
         logic [CNT_W+1:0] hi_on;
         logic [CNT_W+1:0] lo_on;
         logic [CNT_W+1:0] min_on;
         // each switching edge moves in by the dead time
         assign hi_on  = {2'b00, duty_vec[p]}
                       - {2'b00, dead_time_count}; // RULE20
         assign lo_on  = {2'b00, period_count} - {2'b00, duty_vec[p]}
                       - {2'b00, dead_time_count}; // RULE20
         assign min_on = {2'b00, min_pulse_count_reg}; // RULE3
         // negative on-time shows as the top bit set and counts as short
         always_comb begin
            delete_next[2*p]   = hi_on[CNT_W+1] | (hi_on < min_on); // RULE4
            delete_next[2*p+1] = lo_on[CNT_W+1] | (lo_on < min_on); // RULE4
         end
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (rst) begin
         delete_reg <= '0;
      end else if (sync_rise) begin
         delete_reg <= delete_next; // RULE1 RULE2
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // chopping carrier: square wave of 4*(div+1) clocks

   assign chop_last = {gate_carrier_reg[GATE_DIV_LSB +: GATE_DIV_W], 1'b1};

   // toggles every 2*(div+1) clocks, giving a 50 percent wave
   always_ff @(posedge clock) begin
      if (rst) begin
         chop_cnt_reg <= '0;
      end else if (chop_cnt_reg >= chop_last) begin
         chop_cnt_reg <= '0; // RULE14
      end else begin
         chop_cnt_reg <= chop_cnt_reg + 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         carrier_reg <= 1'b0;
      end else if (chop_cnt_reg >= chop_last) begin
         carrier_reg <= ~carrier_reg; // RULE14 RULE21
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output steering, masking and chopping

   generate
      for (genvar p = 0; p < NUM_PHASES; p++) begin : g_out
         logic hi_fix;
         logic lo_fix;
         logic hi_route;
         logic lo_route;
         logic hi_mask;
         logic lo_mask;
         always_comb begin
            // deleted pulse off, complement fully on; if both halves are deleted, both pins are on
            hi_fix = (timing_vec[p][0] & ~delete_reg[2*p])
                   | delete_reg[2*p+1]; // RULE4
            lo_fix = (timing_vec[p][1] & ~delete_reg[2*p+1])
                   | delete_reg[2*p]; // RULE4
            if (steer_active_reg[STEER_XOVER_A_BIT-p]) begin
               hi_route = lo_fix; // RULE6 RULE7
               lo_route = hi_fix; // RULE6 RULE7
            end else begin
               hi_route = hi_fix;
               lo_route = lo_fix;
            end
            // disable gates the routed signal
            hi_mask = hi_route
                    & ~steer_active_reg[STEER_HIGH_A_BIT-2*p]; // RULE9 RULE10
            lo_mask = lo_route
                    & ~steer_active_reg[STEER_LOW_A_BIT-2*p]; // RULE9 RULE10
            pins_next[2*p] = hi_mask
               & (carrier_reg
                  | ~gate_carrier_reg[GATE_CHOP_HI_BIT]); // RULE18 RULE21
            pins_next[2*p+1] = lo_mask
               & (carrier_reg
                  | ~gate_carrier_reg[GATE_CHOP_LO_BIT]); // RULE18 RULE21
         end
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (rst) begin
         pins_reg <= '0;
      end else begin
         pins_reg <= pins_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs

   assign avs_readdata    = rdata_reg;
   assign avs_waitrequest = wait_reg;
   assign phase_a_high    = pins_reg[0];
   assign phase_a_low     = pins_reg[1];
   assign phase_b_high    = pins_reg[2];
   assign phase_b_low     = pins_reg[3];
   assign phase_c_high    = pins_reg[4];
   assign phase_c_low     = pins_reg[5];

endmodule : pos_shaping

/* File: bench/pos_gate_drv.sv */
`timescale 1ns/1ps
module pos_gate_drv (
   // clock and window clear
   input  wire logic       clock,
   input  wire logic       clr,
   // gate inputs, phase a high first
   input  wire logic [5:0] pins,
   // on cycles and turn-on edges per gate
   output logic [15:0]     on_cnt [6],
   output logic [15:0]     up_cnt [6]
);
   logic [5:0] last_reg;
   always_ff @(posedge clock) begin
      last_reg <= pins;
      for (int i = 0; i < 6; i++) begin
         on_cnt[i] <= clr ? 16'h0000 : on_cnt[i] + 16'(pins[i]);
         up_cnt[i] <= clr ? 16'h0000 :
                      up_cnt[i] + 16'(pins[i] & ~last_reg[i]);
      end
   end
endmodule : pos_gate_drv

/* File: bench/pos_shaping_sva.sv */
`timescale 1ns/1ps
module pos_shaping_sva
   import pos_pkg::*;
(
   // clock, reset and bus
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [DATA_W-1:0] avs_writedata,
   input  wire logic              avs_waitrequest,
   // sync and pins
   input  wire logic              period_sync_pulse,
   input  wire logic              phase_a_high,
   input  wire logic              phase_a_low,
   input  wire logic              phase_b_high,
   input  wire logic              phase_b_low,
   input  wire logic              phase_c_high,
   input  wire logic              phase_c_low
);
   logic [8:0] sh_reg;
   logic [8:0] lat_reg;
   logic       sp_reg;
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////
   // shadow of the steering word and its copy latched at sync rise
   always_ff @(posedge clock) begin
      if (rst) begin
         sh_reg   <= STEER_RESET;
         lat_reg  <= STEER_RESET;
         sp_reg   <= 1'b0;
      end else begin
         sp_reg   <= period_sync_pulse;
         if (avs_write && !avs_waitrequest
             && avs_address == OFS_STEERING) begin
            sh_reg <= avs_writedata[8:0];
         end
         // latch on the same edge as the design's sync rise detect
         if (period_sync_pulse && !sp_reg) begin
            lat_reg <= sh_reg;
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   property p_rst_pins;
      $fell(rst) |-> !(phase_a_high | phase_a_low | phase_b_high |
                       phase_b_low | phase_c_high | phase_c_low);
   endproperty
   a_rst_pins: assert property (p_rst_pins)
      else $error("pins not off after reset");
   property p_wait_low; (avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest; endproperty
   a_wait_low: assert property (p_wait_low)
      else $error("access not answered in one cycle");
   property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("waitrequest low longer than one cycle");
   property p_off_ah; lat_reg[4] |=> !phase_a_high; endproperty
   a_off_ah: assert property (p_off_ah)
      else $error("disabled phase a high is on");
   property p_off_al; lat_reg[5] |=> !phase_a_low; endproperty
   a_off_al: assert property (p_off_al)
      else $error("disabled phase a low is on");
   property p_off_bh; lat_reg[2] |=> !phase_b_high; endproperty
   a_off_bh: assert property (p_off_bh)
      else $error("disabled phase b high is on");
   property p_off_bl; lat_reg[3] |=> !phase_b_low; endproperty
   a_off_bl: assert property (p_off_bl)
      else $error("disabled phase b low is on");
   property p_off_ch; lat_reg[0] |=> !phase_c_high; endproperty
   a_off_ch: assert property (p_off_ch)
      else $error("disabled phase c high is on");
   property p_off_cl; lat_reg[1] |=> !phase_c_low; endproperty
   a_off_cl: assert property (p_off_cl)
      else $error("disabled phase c low is on");
endmodule : pos_shaping_sva
bind pos_shaping pos_shaping_sva u_sva (
   .clock, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
   .avs_waitrequest, .period_sync_pulse, .phase_a_high, .phase_a_low,
   .phase_b_high, .phase_b_low, .phase_c_high, .phase_c_low
);

/* File: bench/tb_pos_shaping.sv */
`timescale 1ns/1ps
module tb_pos_shaping
   import pos_pkg::*;
;
   logic              clock, rst, avs_read, avs_write, dbl, sync, clr;
   logic [ADDR_W-1:0] avs_address;
   logic [DATA_W-1:0] avs_writedata, avs_readdata, q;
   logic              avs_waitrequest;
   logic [CNT_W-1:0]  duty [3];
   logic [CNT_W-1:0]  dead, per;
   logic [5:0]        tin, pin;
   logic [15:0]       on_cnt [6], up_cnt [6];
   logic [8:0]        s_prev;
   int                fail_count, check_count, w;
   logic [3:0]        ad [4] = '{4'h0, 4'h4, 4'h8, 4'h2};
   logic [31:0]       msk [3] = '{32'h1FF, 32'h3FF, 32'hFFFF};
   logic [8:0]        st [6] = '{9'h100, 9'h080, 9'h040,
                                 9'h0A7, 9'h03F, 9'h000};
   logic [5:0]        pat [2] = '{6'b100110, 6'b011001};
   logic [9:0]        gt [4] = '{10'h101, 10'h100, 10'h1FF, 10'h203};
   pos_shaping DUT (
      .clock, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
      .double_update_mode(dbl), .period_sync_pulse(sync),
      .duty_phase_a(duty[0]), .duty_phase_b(duty[1]),
      .duty_phase_c(duty[2]), .dead_time_count(dead), .period_count(per),
      .timing_a_high(tin[5]), .timing_a_low(tin[4]),
      .timing_b_high(tin[3]), .timing_b_low(tin[2]),
      .timing_c_high(tin[1]), .timing_c_low(tin[0]),
      .phase_a_high(pin[5]), .phase_a_low(pin[4]), .phase_b_high(pin[3]),
      .phase_b_low(pin[2]), .phase_c_high(pin[1]), .phase_c_low(pin[0])
   );
   pos_gate_drv PART (.clock, .clr, .pins(pin), .on_cnt, .up_cnt);
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         fail_count++;
      end
   endtask : chk
   task automatic bus(input logic wr, input logic [3:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge clock);
      avs_address   <= a;
      avs_write     <= wr;
      avs_read      <= ~wr;
      avs_writedata <= d;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      if (avs_waitrequest !== 1'b0) begin
         fail_count++;
         close_out();
      end
   endtask : bus
   task automatic sy;
      @(posedge clock);
      sync <= 1'b1;
      @(posedge clock);
      sync <= 1'b0;
      repeat (4) @(posedge clock);
   endtask : sy
   task automatic pc(input logic [5:0] e);
      repeat (2) @(posedge clock);
      chk(32'(pin), 32'(e));
   endtask : pc
   // expected pins: swap crossed pairs, then clear disabled outputs
   function automatic logic [5:0] ex(input logic [8:0] s, input logic [5:0] t);
      logic [5:0] r;
      r = t;
      if (s[8]) r[5:4] = {t[4], t[5]};
      if (s[7]) r[3:2] = {t[2], t[3]};
      if (s[6]) r[1:0] = {t[0], t[1]};
      return r & ~{s[4], s[5], s[2], s[3], s[0], s[1]};
   endfunction : ex
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 4'h0;
      avs_writedata = 32'h0; dbl = 1'b0; sync = 1'b0; clr = 1'b0;
      tin = 6'h00; dead = 16'h0003; per = 16'h00C8; s_prev = 9'h000;
      duty = '{3{16'h0064}};
      fail_count = 0;
      check_count = 0;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         bus(1'b0, ad[i], 32'h0);
         chk(q, 32'h0);
      end
      chk(32'(pin), 32'h0);
      $display("test reset_values done");
      for (int i = 0; i < 3; i++) begin
         bus(1'b1, ad[i], 32'hFFFFFFFF);
         bus(1'b0, ad[i], 32'h0);
         chk(q, msk[i]);
         bus(1'b1, ad[i], 32'h0);
      end
      $display("test register_widths done");
      for (int i = 0; i < 6; i++) begin
         bus(1'b1, OFS_STEERING, 32'(st[i]));
         pc(ex(s_prev, tin));
         sy();
         s_prev = st[i];
         for (int j = 0; j < 2; j++) begin
            tin <= pat[j];
            pc(ex(st[i], pat[j]));
         end
      end
      $display("test steering done");
      bus(1'b1, OFS_MIN_PULSE, 32'h0000000A);
      duty <= '{16'h0005, 16'h000D, 16'h000C};
      tin  <= 6'b101010;
      sy();
      pc(6'b011001);
      dbl     <= 1'b1;
      duty[0] <= 16'h0064;
      duty[2] <= 16'h00BE;
      tin     <= 6'b010101;
      sy();
      pc(6'b010110);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(32'(q[STAT_HALF_BIT]), 32'h1);
      dbl <= 1'b0;
      $display("test deletion done");
      bus(1'b1, OFS_MIN_PULSE, 32'h0);
      duty <= '{3{16'h0064}};
      tin  <= 6'b100100;
      sy();
      bus(1'b0, OFS_STATUS, 32'h0);
      chk(32'(q[STAT_HALF_BIT]), 32'h0);
      for (int i = 0; i < 4; i++) begin
         bus(1'b1, OFS_GATE, 32'(gt[i]));
         w = 16 * (int'(gt[i][7:0]) + 1);
         repeat (4) @(posedge clock);
         clr <= 1'b1;
         @(posedge clock);
         clr <= 1'b0;
         repeat (w + 1) @(posedge clock);
         chk(32'(on_cnt[5]), 32'(gt[i][8] ? w / 2 : w));
         chk(32'(up_cnt[5]), 32'(gt[i][8] ? 4 : 0));
         chk(32'(on_cnt[2]), 32'(gt[i][9] ? w / 2 : w));
         chk(32'(on_cnt[4]), 32'h0);
      end
      $display("test chopping done");
      close_out();
   end
endmodule : tb_pos_shaping
